// ---- design/perf_pkg.sv ----
// shared constants, register map and carrier types of the error-second monitor
package perf_pkg;

  // sizes of the statistics store
  localparam int NPORT = 2;
  localparam int NCNT  = 6;
  localparam int NSLOT = 12;
  localparam int CW    = 16;   // per-slot counter width
  localparam int TW    = 20;   // running total width
  localparam int EW    = 24;   // per-second error and bit tally width
  localparam int SW    = 16;   // seconds-in-slot width
  localparam int RW    = 4;    // run length counter width

  // timing: one second at a 10 ns clock
  localparam int SEC_NS       = 1000000000;
  localparam int CLK_NS       = 10;
  localparam int CYC_PER_SEC  = SEC_NS / CLK_NS;
  localparam int SEC_PER_SLOT = 7200;  // twelve slots span one day

  // severity and run thresholds
  localparam int BER_DEN = 1000;       // one error per thousand bits
  localparam int RUN_LEN = 10;

  // counter index within a port
  localparam int CNT_IN_ERR  = 0;
  localparam int CNT_IN_SEV  = 1;
  localparam int CNT_IN_CON  = 2;
  localparam int CNT_OUT_ERR = 3;
  localparam int CNT_OUT_SEV = 4;
  localparam int CNT_OUT_CON = 5;

  // correction method of a port
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_VOTE = 2'h1;
  localparam logic [1:0] MODE_BCH  = 2'h2;

  // register byte addresses
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_MASK = 12'h008;
  localparam logic [11:0] A_TIME = 12'h00c;
  localparam logic [11:0] A_CUR  = 12'h100;
  localparam logic [11:0] A_TOT  = 12'h200;
  localparam logic [11:0] A_HIST = 12'h400;

  // field positions
  localparam int F_REFRESH = 8;
  localparam int F_CNT     = 2;   // counter index, 3 bits
  localparam int F_SLOT    = 5;   // history slot, 4 bits
  localparam int F_PORT    = 5;   // port bit in snapshot and total pages
  localparam int F_HPORT   = 9;   // port bit in the history page
  localparam int CNT_AW    = 3;
  localparam int SLOT_AW   = 4;

  // interrupt status layout
  localparam int IRQ_W  = 5;
  localparam int I_IN   = 0;      // input severe second, one bit per port
  localparam int I_OUT  = 2;      // output severe second, one bit per port
  localparam int I_ROLL = 4;      // slot rollover

  // incoming decoder stream of one port
  typedef struct packed {
    logic valid;
    logic rx_bit;
    logic fix_bit;
    logic bch_err;
    logic vote_err;
    logic uncorr;
  } stream_s;

  // verdict on one finished second
  typedef struct packed {
    logic v;
    logic errored;
    logic severe;
    logic consec;
  } sec_res_s;

endpackage : perf_pkg

// ---- design/second_tick.sv ----
// one-second enable pulse divided down from the system clock
module second_tick
  import perf_pkg::*;
#(
  parameter int CYCLES = CYC_PER_SEC
)
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // one-cycle pulse per second
  output      logic tick_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } tick_s;

  tick_s st;
  tick_s next_st;

  // wrap exactly every CYCLES clocks so every second has the same length
  always_comb
  begin
    next_st      = st;
    next_st.tick = (st.cnt == 32'(CYCLES - 1)); // [RULE_17]
    next_st.cnt  = next_st.tick ? '0 : st.cnt + 32'h1;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick_o = st.tick;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  tick_period_a: assert property (st.cnt == 32'(CYCLES - 1) |=> tick_o && st.cnt == '0) // [RULE_17]
    else $error("second tick not at end of count");

endmodule : second_tick

// ---- design/second_grader.sv ----
// grades each second of one error stream: errored, severe, consecutive run
module second_grader
  import perf_pkg::*;
(
  // clock and reset
  input  wire logic     clock_i,
  input  wire logic     rst_n_i,
  // per-bit events
  input  wire logic     en_i,
  input  wire logic     bit_i,
  input  wire logic     err_i,
  input  wire logic     tick_i,
  // verdict, valid one cycle after the tick
  output      sec_res_s res_o
);

  typedef enum logic {RUN_IDLE, RUN_ON} run_e;

  typedef struct packed {
    run_e          state;
    logic [RW-1:0] run;
    logic [EW-1:0] errs;
    logic [EW-1:0] bits;
    sec_res_s      res;
  } grade_s;

  grade_s          st;
  grade_s          next_st;
  logic [EW-1:0]   errs_now;
  logic [EW-1:0]   bits_now;
  logic [EW+9:0]   scaled;
  logic            sev_now;
  logic            last_run;

  // tally the second; the tick cycle's own events still belong to it
  always_comb
  begin
    next_st      = st;
    errs_now     = st.errs + EW'(err_i);
    bits_now     = st.bits + EW'(bit_i);
    scaled       = (EW+10)'(errs_now) * (EW+10)'(BER_DEN);
    sev_now      = scaled > (EW+10)'(bits_now); // [RULE_11] [RULE_14]
    last_run     = (st.run == RW'(RUN_LEN - 1));
    next_st.res  = '0;
    next_st.errs = errs_now;
    next_st.bits = bits_now;
    if (!en_i)
    begin
      // disabled: nothing gathered, run history forgotten
      next_st       = '0; // [RULE_01]
      next_st.res.v = tick_i;
    end
    else if (tick_i)
    begin
      next_st.errs        = '0;
      next_st.bits        = '0;
      next_st.res.v       = 1'b1;
      next_st.res.errored = (errs_now != '0); // [RULE_10] [RULE_13]
      next_st.res.severe  = sev_now;
      case (st.state)
        RUN_IDLE:
        begin
          // the tenth severe second in a row is the first one counted
          next_st.run = sev_now ? st.run + RW'(1) : '0;
          if (sev_now && last_run)
          begin
            next_st.state      = RUN_ON; // [RULE_12] [RULE_15]
            next_st.run        = '0;
            next_st.res.consec = 1'b1;
          end
        end
        RUN_ON:
        begin
          // the tenth clean second in a row ends the run and is not counted
          next_st.res.consec = 1'b1;
          next_st.run        = sev_now ? '0 : st.run + RW'(1);
          if (!sev_now && last_run)
          begin
            next_st.state      = RUN_IDLE; // [RULE_12] [RULE_15]
            next_st.run        = '0;
            next_st.res.consec = 1'b0;
          end
        end
        default:
          next_st.state = RUN_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign res_o = st.res;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  off_silent_a: assert property (tick_i && !en_i |=> res_o.v && res_o == 4'h8) // [RULE_01]
    else $error("disabled stream reported a graded second");
  errored_sec_a: assert property (tick_i && en_i && errs_now != '0 |=> res_o.v && res_o.errored) // [RULE_10]
    else $error("errored second missed");
  run_start_a: assert property (tick_i && en_i && sev_now && st.state == RUN_IDLE && last_run // [RULE_12]
                                |=> res_o.consec && st.state == RUN_ON)
    else $error("consecutive run did not start on tenth severe second");
  run_stop_a: assert property (tick_i && en_i && !sev_now && st.state == RUN_ON && last_run // [RULE_15]
                               |=> !res_o.consec && st.state == RUN_IDLE)
    else $error("consecutive run did not stop on tenth clean second");

endmodule : second_grader

// ---- design/perf_monitor.sv ----
// error-second performance monitor: bus slave, two ports, history, interrupt
// How it works
// (RULE_01) a port gathers statistics only while voting or polynomial correction is on
// (RULE_02) each of the two ports keeps its own independent statistics
// (RULE_03) polynomial mode takes decoder check errors as detected input errors
// (RULE_04) every detected input error feeds input errored, severe, consecutive counts
// (RULE_05) polynomial mode forwards the corrected bit toward the loop
// (RULE_06) uncorrectable polynomial errors also feed the three output counts
// (RULE_07) voting mode takes the voter's error decision as input errors
// (RULE_08) voting mode leaves all three output counts untouched
// (RULE_09) twelve history slots cover a day, with running totals across them
// (RULE_10) input errored seconds count seconds with at least one input error
// (RULE_11) input severe seconds count seconds above one error per thousand bits
// (RULE_12) input consecutive count runs from ten severe to ten clean seconds
// (RULE_13) output errored seconds count seconds with uncorrectable errors
// (RULE_14) output severe seconds count seconds above one per thousand, polynomial only
// (RULE_15) output consecutive count runs ten severe to ten clean, polynomial only
// (RULE_16) software refresh takes the snapshot that reads return
// (RULE_17) an exact one-second tick is divided from the system clock
// (RULE_18) slot end shifts current into history, drops oldest, clears, updates totals
//
// The register addresses and the Wishbone slave port are this design's own decisions.
module perf_monitor
  import perf_pkg::*;
#(
  parameter int CYCLES_PER_SEC = CYC_PER_SEC,
  parameter int SECS_PER_SLOT  = SEC_PER_SLOT
)
(
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  // classic wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [11:0]          wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output      logic [31:0]          wb_dat_o,
  output      logic                 wb_ack_o,
  // interrupt
  output      logic                 irq_o,
  // decoder streams from the network side
  input  wire stream_s [NPORT-1:0]  stream_i,
  // data toward the four-wire loop
  output      logic [NPORT-1:0]     loop_bit_o,
  output      logic [NPORT-1:0]     loop_valid_o
);

  typedef logic [NPORT-1:0][NCNT-1:0][CW-1:0] cnt_t;
  typedef logic [NPORT-1:0][NCNT-1:0][TW-1:0] tot_t;

  typedef struct packed {
    logic                   ack;
    logic [31:0]            rdat;
    logic [NPORT-1:0][1:0]  mode;
    logic [IRQ_W-1:0]       stat;
    logic [IRQ_W-1:0]       mask;
    logic                   irq;
    logic [SW-1:0]          secs;
    cnt_t                   cur;
    cnt_t                   snap;
    tot_t                   tot;
    tot_t                   tsnap;
    cnt_t [NSLOT-1:0]       hist;
    logic [NPORT-1:0]       lbit;
    logic [NPORT-1:0]       lval;
  } mon_s;

  mon_s                  st;
  mon_s                  next_st;
  logic                  tick;
  sec_res_s [NPORT-1:0]  in_res;
  sec_res_s [NPORT-1:0]  out_res;
  logic [NPORT-1:0]      in_en;
  logic [NPORT-1:0]      out_en;
  logic [NPORT-1:0]      in_err;
  logic [NPORT-1:0]      out_err;
  cnt_t                  cur_upd;
  logic [NCNT-1:0]       inc;
  logic [IRQ_W-1:0]      ev;
  logic [IRQ_W-1:0]      clr;
  logic [31:0]           wmask;
  logic [31:0]           rword;
  logic [CNT_AW-1:0]     k_sel;
  logic [SLOT_AW-1:0]    s_sel;
  logic                  wr;
  logic                  refresh;
  logic                  sec_v;
  logic                  roll;

  // byte lanes of a write
  function automatic logic [31:0] lanes(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
      m[8*i +: 8] = {8{sel[i]}};
    return m;
  endfunction : lanes

  // single word match, byte offset bits ignored
  function automatic logic word_hit(input logic [11:0] adr, input logic [11:0] base);
    return adr[11:2] == base[11:2];
  endfunction : word_hit

  // 64-byte page match for snapshot and total pages
  function automatic logic page_hit(input logic [11:0] adr, input logic [11:0] base);
    return adr[11:6] == base[11:6];
  endfunction : page_hit

  // methods that gather statistics; the spare code 3 counts as off
  function automatic logic gathers(input logic [1:0] mode);
    return (mode == MODE_VOTE) || (mode == MODE_BCH);
  endfunction : gathers

  // shared one-second time base
  second_tick #(
    .CYCLES (CYCLES_PER_SEC)
  ) u_tick (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .tick_o  (tick)
  );

  // one input and one output grader per port, fully independent
  genvar g;
  generate
    for (g = 0; g < NPORT; g++)
    begin : g_port
      // no correction, no statistics; output side only for polynomial
      assign in_en[g]   = gathers(st.mode[g]); // [RULE_01] [RULE_02]
      assign out_en[g]  = (st.mode[g] == MODE_BCH); // [RULE_08] [RULE_13] [RULE_14] [RULE_15]
      // the active corrector decides what counts as an input error
      assign in_err[g]  = stream_i[g].valid &
                          ((st.mode[g] == MODE_BCH) ? stream_i[g].bch_err // [RULE_03]
                                                    : stream_i[g].vote_err); // [RULE_07]
      assign out_err[g] = stream_i[g].valid & stream_i[g].uncorr; // [RULE_06]

      second_grader u_in (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .en_i    (in_en[g]),
        .bit_i   (stream_i[g].valid),
        .err_i   (in_err[g]),
        .tick_i  (tick),
        .res_o   (in_res[g])
      );

      second_grader u_out (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .en_i    (out_en[g]),
        .bit_i   (stream_i[g].valid),
        .err_i   (out_err[g]),
        .tick_i  (tick),
        .res_o   (out_res[g])
      );
    end
  endgenerate

  // read mux: counters come from the snapshot, history is read live
  always_comb
  begin
    rword = '0;
    k_sel = wb_adr_i[F_CNT +: CNT_AW];
    s_sel = wb_adr_i[F_SLOT +: SLOT_AW];
    if (word_hit(wb_adr_i, A_CTRL))
      rword = 32'(st.mode);
    else if (word_hit(wb_adr_i, A_STAT))
      rword = 32'(st.stat);
    else if (word_hit(wb_adr_i, A_MASK))
      rword = 32'(st.mask);
    else if (word_hit(wb_adr_i, A_TIME))
      rword = 32'(st.secs);
    else if (page_hit(wb_adr_i, A_CUR) && k_sel < CNT_AW'(NCNT))
      rword = 32'(st.snap[wb_adr_i[F_PORT]][k_sel]); // [RULE_16]
    else if (page_hit(wb_adr_i, A_TOT) && k_sel < CNT_AW'(NCNT))
      rword = 32'(st.tsnap[wb_adr_i[F_PORT]][k_sel]); // [RULE_16]
    else if (wb_adr_i[11:10] == A_HIST[11:10] && k_sel < CNT_AW'(NCNT) && s_sel < SLOT_AW'(NSLOT))
      rword = 32'(st.hist[s_sel][wb_adr_i[F_HPORT]][k_sel]);
  end

  // next state: bus, statistics, history, interrupt, loop data
  always_comb
  begin
    next_st = st;
    sec_v   = in_res[0].v;
    roll    = sec_v && (st.secs == SW'(SECS_PER_SLOT - 1));
    wmask   = lanes(wb_sel_i);
    // writes land on the edge where the master sees ack
    wr      = st.ack & wb_cyc_i & wb_stb_i & wb_we_i;
    refresh = wr && word_hit(wb_adr_i, A_CTRL) && wb_dat_i[F_REFRESH] && wmask[F_REFRESH];
    clr     = (wr && word_hit(wb_adr_i, A_STAT)) ? IRQ_W'(wb_dat_i & wmask) : '0;
    inc     = '0;
    ev      = '0;

    // answer one cycle after the request, then drop for a cycle
    next_st.ack  = wb_cyc_i & wb_stb_i & ~st.ack;
    next_st.rdat = (next_st.ack && !wb_we_i) ? rword : '0;

    // control and mask writes honour byte lanes
    if (wr && word_hit(wb_adr_i, A_CTRL))
      next_st.mode = 4'((32'(st.mode) & ~wmask) | (wb_dat_i & wmask));
    if (wr && word_hit(wb_adr_i, A_MASK))
      next_st.mask = IRQ_W'((32'(st.mask) & ~wmask) | (wb_dat_i & wmask));

    // add each port's verdict to its current slot
    for (int p = 0; p < NPORT; p++)
    begin
      inc[CNT_IN_ERR]  = in_res[p].errored;  // [RULE_04] [RULE_10]
      inc[CNT_IN_SEV]  = in_res[p].severe;   // [RULE_04] [RULE_11]
      inc[CNT_IN_CON]  = in_res[p].consec;   // [RULE_04] [RULE_12]
      inc[CNT_OUT_ERR] = out_res[p].errored; // [RULE_06] [RULE_13]
      inc[CNT_OUT_SEV] = out_res[p].severe;  // [RULE_06] [RULE_14]
      inc[CNT_OUT_CON] = out_res[p].consec;  // [RULE_06] [RULE_15]
      for (int k = 0; k < NCNT; k++)
        cur_upd[p][k] = st.cur[p][k] + CW'(inc[k]);
      ev[I_IN + p]  = in_res[p].v & in_res[p].severe;
      ev[I_OUT + p] = out_res[p].v & out_res[p].severe;
    end
    ev[I_ROLL] = roll;

    // seconds advance the current slot
    if (sec_v)
    begin
      next_st.cur  = cur_upd;
      next_st.secs = st.secs + SW'(1);
    end

    // slot end: newest in, oldest out, totals follow both
    if (roll)
    begin
      next_st.secs = '0;
      next_st.cur  = '0; // [RULE_18]
      next_st.hist = {st.hist[NSLOT-2:0], cur_upd}; // [RULE_18]
      for (int p = 0; p < NPORT; p++)
        for (int k = 0; k < NCNT; k++)
          next_st.tot[p][k] = st.tot[p][k] + TW'(cur_upd[p][k])
                              - TW'(st.hist[NSLOT-1][p][k]); // [RULE_09] [RULE_18]
    end

    // snapshot only on request, so reads stay stable between refreshes
    if (refresh)
    begin
      next_st.snap  = st.cur;  // [RULE_16]
      next_st.tsnap = st.tot;  // [RULE_16]
    end

    // sticky status: a new event beats a clear in the same cycle
    next_st.stat = (st.stat & ~clr) | ev;
    next_st.irq  = |(next_st.stat & next_st.mask);

    // loop data: corrected bit under polynomial mode, raw bit otherwise
    for (int p = 0; p < NPORT; p++)
    begin
      next_st.lval[p] = stream_i[p].valid;
      if (stream_i[p].valid)
        next_st.lbit[p] = (st.mode[p] == MODE_BCH) ? stream_i[p].fix_bit // [RULE_05]
                                                   : stream_i[p].rx_bit;
    end
  end

  // single state register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  // outputs straight from flops
  assign wb_ack_o     = st.ack;
  assign wb_dat_o     = st.rdat;
  assign irq_o        = st.irq;
  assign loop_bit_o   = st.lbit;
  assign loop_valid_o = st.lval;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  snap_hold_a: assert property (!refresh |=> st.snap == $past(st.snap) && st.tsnap == $past(st.tsnap)) // [RULE_16]
    else $error("snapshot changed without refresh");
  snap_take_a: assert property (refresh |=> st.snap == $past(st.cur) && st.tsnap == $past(st.tot)) // [RULE_16]
    else $error("refresh did not capture current values");
  roll_shift_a: assert property (roll |=> st.hist[0] == $past(cur_upd) && st.cur == '0 // [RULE_18]
                                 && st.hist[NSLOT-1] == $past(st.hist[NSLOT-2]))
    else $error("slot rollover did not shift history");
  roll_total_a: assert property (roll |=> st.tot[1][CNT_IN_SEV] == $past(st.tot[1][CNT_IN_SEV]) // [RULE_09]
                                 + TW'($past(cur_upd[1][CNT_IN_SEV]))
                                 - TW'($past(st.hist[NSLOT-1][1][CNT_IN_SEV])))
    else $error("running total wrong after rollover");
  secs_range_a: assert property (st.secs < SW'(SECS_PER_SLOT)) // [RULE_09]
    else $error("slot second count out of range");

  // counting per port
  vote_out_a: assert property (sec_v && !roll && st.mode[1] != MODE_BCH && $past(st.mode[1]) != MODE_BCH // [RULE_08]
                               |=> st.cur[1][CNT_OUT_ERR] == $past(st.cur[1][CNT_OUT_ERR]))
    else $error("output count moved outside polynomial mode");
  vote_out0_a: assert property (sec_v && st.mode[0] == MODE_VOTE && $past(st.mode[0]) == MODE_VOTE // [RULE_08]
                                && !roll |=> st.cur[0][CNT_OUT_SEV] == $past(st.cur[0][CNT_OUT_SEV]))
    else $error("output severe count moved in voting mode");
  off_still_a: assert property (sec_v && !roll && st.mode[0] == MODE_OFF && $past(st.mode[0]) == MODE_OFF // [RULE_01]
                                |=> st.cur[0] == $past(st.cur[0]))
    else $error("statistics gathered with correction off");
  in_count_a: assert property (sec_v && !roll && in_res[0].errored // [RULE_04]
                               |=> st.cur[0][CNT_IN_ERR] == $past(st.cur[0][CNT_IN_ERR]) + CW'(1))
    else $error("input errored second not counted");
  out_count_a: assert property (sec_v && !roll && out_res[1].severe // [RULE_06]
                                |=> st.cur[1][CNT_OUT_SEV] == $past(st.cur[1][CNT_OUT_SEV]) + CW'(1))
    else $error("output severe second not counted");

  // correction mode decode and loop data
  code_off_a: assert property (st.mode[0] != MODE_VOTE && st.mode[0] != MODE_BCH // [RULE_01]
                               |-> !in_en[0] && !out_en[0])
    else $error("statistics enabled without correction");
  fwd_fix_a: assert property (stream_i[0].valid && st.mode[0] == MODE_BCH // [RULE_05]
                              |=> loop_valid_o[0] && loop_bit_o[0] == $past(stream_i[0].fix_bit))
    else $error("corrected bit not forwarded");
  fwd_valid_a: assert property (stream_i[1].valid |=> loop_valid_o[1]) // [RULE_05]
    else $error("loop bit not flagged valid");

  // bus handshake: one answer per request, data only with ack
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  rdat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data shown without ack");
  mask_land_a: assert property (wr && word_hit(wb_adr_i, A_MASK) && wb_sel_i[0]
                                |=> st.mask == $past(wb_dat_i[IRQ_W-1:0]))
    else $error("mask write lost");

  // sticky status and level interrupt
  stat_set_a: assert property (ev != '0 |=> (st.stat & $past(ev)) == $past(ev))
    else $error("status event lost");
  irq_level_a: assert property (irq_o == |(st.stat & st.mask))
    else $error("interrupt level wrong");

  roll_c: cover property (roll);
  refresh_c: cover property (refresh ##1 !wb_ack_o);
  consec_c: cover property (in_res[0].v && in_res[0].consec);
  out_sev_c: cover property (out_res[1].v && out_res[1].severe);
  vote_sev_c: cover property (in_res[0].v && in_res[0].severe && st.mode[0] == MODE_VOTE);

endmodule : perf_monitor

// ---- test/stream_src.sv ----
// stand-in for the network side decoders of both ports
module stream_src
  import perf_pkg::*;
(
  // clock and reset
  input  wire logic                rst_n_i,
  input  wire logic                clock_i,
  // error controls per port
  input  wire logic [NPORT-1:0]    err_i,
  input  wire logic [NPORT-1:0]    unc_i,
  // decoder streams
  output      stream_s [NPORT-1:0] stream_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic rx;

  // a bit every cycle; toggling data makes the loop path visible
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rx <= 1'b0;
    else
      rx <= ~rx;
  end

  // corrected bit is the inverse so polynomial and vote paths differ
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
      stream_o[p] = '{1'b1, rx, ~rx, err_i[p], err_i[p], err_i[p] & unc_i[p]};
  end
endmodule : stream_src

// ---- test/perf_monitor_test.sv ----
// self-checking bench of the error-second monitor
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module test_error_second_perf_monitor
  import perf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPS = 20;
  localparam int SPS = 40;
  logic                clock_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [11:0]         wb_adr_i;
  logic [3:0]          wb_sel_i;
  logic [31:0]         wb_dat_i, wb_dat_o, q, t0;
  logic [NPORT-1:0]    loop_bit_o, loop_valid_o, err_r, unc_r;
  stream_s [NPORT-1:0] stream_i;
  int                  err_count, cmp_count;

  perf_monitor #(.CYCLES_PER_SEC(CPS), .SECS_PER_SLOT(SPS)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .stream_i(stream_i),
    .loop_bit_o(loop_bit_o), .loop_valid_o(loop_valid_o));
  stream_src i_src (.rst_n_i(rst_n_i), .clock_i(clock_i), .err_i(err_r), .unc_i(unc_r), .stream_o(stream_i));

  always #5 clock_i = ~clock_i;

  task test_done;
    begin
      $display("mismatches %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask : test_done

  // a wait that used up its bound ends the run as a failure
  task give_up(input string what);
    begin
      err_count++;
      $display("unexpected at %0t: %s", $time, what);
      test_done;
    end
  endtask : give_up

  // one classic cycle; holds everything until ack, then one idle cycle
  task wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do
      begin
        @(posedge clock_i);
        n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50)
        give_up("no ack");
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clock_i);
    end
  endtask : wb

  // reads six counters of both ports; in and out expectations per port
  task chk_page(input logic [11:0] b, input int ps, input logic [31:0] ei0, eo0, ei1, eo1);
    begin
      for (int p = 0; p < NPORT; p++)
        for (int k = 0; k < NCNT; k++)
        begin
          wb(1'b0, b + 12'(p * ps + k * 4), 32'h0);
          `CHK(q, (k < 3) ? (p ? ei1 : ei0) : (p ? eo1 : eo0))
        end
    end
  endtask : chk_page

  // errors under the spare code 3, then off, leave nothing behind
  task t_off;
    begin
      wb(1'b1, A_CTRL, 32'hf);
      err_r <= 2'b11;
      repeat (2 * CPS) @(posedge clock_i);
      err_r <= 2'b00;
      wb(1'b1, A_CTRL, 32'h100);
      chk_page(A_CUR, 32, 0, 0, 0, 0);
      wb(1'b0, 12'h0f0, 32'h0);
      `CHK(q, 32'h0)
    end
  endtask : t_off

  // port0 voting, port1 polynomial, twelve errored seconds then clean
  task t_err;
    int n;
    begin
      wb(1'b1, A_CTRL, 32'h9);
      wb(1'b1, A_MASK, 32'h10);
      wb(1'b0, A_TIME, 32'h0);
      t0 = q;
      n = 0;
      while (q === t0 && n < 40)
      begin
        wb(1'b0, A_TIME, 32'h0);
        n++;
      end
      if (q === t0)
        give_up("time never advanced");
      t0 = q;
      repeat (5 * CPS - 3) @(posedge clock_i);
      wb(1'b0, A_TIME, 32'h0);
      `CHK(q, t0 + 32'h5)
      err_r <= 2'b11;
      repeat (12 * CPS - 14) @(posedge clock_i);
      `CHK(loop_valid_o, 2'b11)
      `CHK(loop_bit_o, {stream_i[1].rx_bit, ~stream_i[0].rx_bit})
      err_r <= 2'b00;
      wb(1'b0, A_CUR, 32'h0);
      `CHK(q, 32'h0)
      repeat (11 * CPS) @(posedge clock_i);
      wb(1'b1, A_CTRL, 32'h109);
      chk_page(A_CUR, 32, 12, 0, 12, 12);
      `CHK(irq_o, 1'b0)
    end
  endtask : t_err

  // slot end moves the counts into history and totals, raises the interrupt
  task t_roll;
    int n;
    begin
      n = 0;
      q = 32'h0;
      while (q[I_ROLL] !== 1'b1 && n < 200)
      begin
        wb(1'b0, A_STAT, 32'h0);
        n++;
      end
      if (q[I_ROLL] !== 1'b1)
        give_up("no slot rollover");
      `CHK(q, 32'h1b)
      `CHK(irq_o, 1'b1)
      wb(1'b1, A_STAT, 32'h10);
      wb(1'b0, A_STAT, 32'h0);
      `CHK(q, 32'h0b)
      `CHK(irq_o, 1'b0)
      wb(1'b1, A_CTRL, 32'h109);
      chk_page(A_TOT, 32, 12, 0, 12, 12);
      chk_page(A_CUR, 32, 0, 0, 0, 0);
      chk_page(A_HIST, 512, 12, 0, 12, 12);
    end
  endtask : t_roll

  // main sequence
  initial
  begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    err_r = 2'b00;
    unc_r = 2'b11;
    err_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    t_off;
    t_err;
    t_roll;
    test_done;
  end
endmodule : test_error_second_perf_monitor
